// ===== hw/scs_ctrl.sv
// Control and status register of the two-wire serial interface, with pin logic.
// Contract
// - Bit 7 reads one while bus master.
// - Master set on START, cleared STOP/arbitration.
// - Bit 6 reads one while transmitting byte.
// - Transmit indicator follows START, buffer write, loss.
// - Writing begin flag one requests START.
// - Begin flag set on START plus address.
// - End flag requests STOP, cleared when sent.
// - End flag set on slave or lost STOP.
// - Bit 3 requests software ACK value.
// - Bit 2 flags three arbitration loss causes and a lost STOP.
// - Clearing pending flag clears arbitration loss.
// - Bit 1 shows received ACK, selects sent.
// - Pending flag holds SCL low, stalls bus.
// - Write zero clears pending, one forces it.
// - Pending flag set by six bus events.
// - Unwritten ACK value sends a NACK.
// - Both flags: STOP then START.
// - START waits for free bus, flag stays.
// - Automatic mode drives ACK bit on bus.
module scs_ctrl
  import scs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  input wire logic byte_buffer_wr,
  input wire logic auto_acknowledge_enable,
  input wire logic eng_start_gen,
  input wire logic eng_stop_gen,
  input wire logic eng_frame_begin,
  input wire logic eng_byte_tx,
  input wire logic eng_ack_rx_low,
  input wire logic eng_byte_rx,
  input wire logic eng_addr_rx,
  input wire logic eng_addressed,
  input wire logic eng_ack_slot,
  input wire logic eng_ack_cycle_end,
  input wire logic eng_scl_low_arb,
  input wire logic eng_sda_low_arb,
  output logic start_req,
  output logic stop_req,
  output logic stall,
  output logic transmitter_indicator,
  output logic irq,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);

  logic master_reg;
  logic transmitter_indicator_reg;
  logic begin_condition_flag_reg;
  logic end_condition_flag_reg;
  logic ack_value_request_reg;
  logic arbitration_lost_flag_reg;
  logic ack_reg;
  logic pending_reg;
  logic buf_written_reg;
  logic [7:0] rdata_reg;
  logic start_s1_reg, start_s2_reg, start_s3_reg;
  logic stop_s1_reg, stop_s2_reg, stop_s3_reg;
  logic free_s1_reg, free_s2_reg;
  logic ctrl_sel, ctrl_wr;
  logic start_det, stop_det;
  logic foreign_start, unwanted_restart;
  logic lost_to_stop, slave_stop;
  logic arb_loss, pend_set, pend_clear;
  logic [7:0] status;

  scs_link_if lk_if ();

  scs_link u_link (
    .link_clk(link_clk),
    .rst(rst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .scl_out(scl_out),
    .scl_oe(scl_oe),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .lk(lk_if.link)
  );

  // Register port decode; the register answers at one address only.
  assign ctrl_sel = (sfr_addr == SCS_CTRL_ADDR);
  assign ctrl_wr = sfr_wr & ctrl_sel;

  // Toggle receivers for conditions seen on the pins; the first stage feeds only the second.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      start_s1_reg <= 1'b0;
      start_s2_reg <= 1'b0;
      start_s3_reg <= 1'b0;
      stop_s1_reg <= 1'b0;
      stop_s2_reg <= 1'b0;
      stop_s3_reg <= 1'b0;
    end else begin
      start_s1_reg <= lk_if.start_tgl;
      start_s2_reg <= start_s1_reg;
      start_s3_reg <= start_s2_reg;
      stop_s1_reg <= lk_if.stop_tgl;
      stop_s2_reg <= stop_s1_reg;
      stop_s3_reg <= stop_s2_reg;
    end
  end

  // Bus-free level from the pin side, two stages.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      free_s1_reg <= SCS_BUS_FREE_RESET;
      free_s2_reg <= SCS_BUS_FREE_RESET;
    end else begin
      free_s1_reg <= lk_if.bus_free;
      free_s2_reg <= free_s1_reg;
    end
  end

  assign start_det = start_s2_reg ^ start_s3_reg;
  assign stop_det = stop_s2_reg ^ stop_s3_reg;

  // Our own START and STOP are seen on the pins too, a few cycles late.
  // By then the master bit, and for a START also the begin flag, tells them apart from another party's.
  assign foreign_start = start_det & ~master_reg;
  assign unwanted_restart = start_det & master_reg & ~begin_condition_flag_reg;
  assign lost_to_stop = stop_det & master_reg;
  assign slave_stop = stop_det & ~master_reg & eng_addressed;

  // Any of the three loss causes, plus a STOP that was not ours.
  assign arb_loss = eng_scl_low_arb | eng_sda_low_arb | unwanted_restart | lost_to_stop;

  // Events that raise the pending flag.
  assign pend_set = eng_start_gen | arb_loss | eng_byte_tx | eng_byte_rx | eng_addr_rx | slave_stop;
  assign pend_clear = ctrl_wr & ~sfr_wdata[SCS_BIT_PEND];

  // Master role: a loss of arbitration beats a START in the same cycle.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      master_reg <= SCS_CTRL_RESET[SCS_BIT_MASTER];
    end else if (arb_loss || eng_stop_gen) begin
      master_reg <= 1'b0;
    end else if (eng_start_gen) begin
      master_reg <= 1'b1;
    end
  end

  // Remembers a buffer write so the next frame knows it transmits.
  // A write in the frame-begin cycle is used by that frame and must not
  // linger, or a later frame would wrongly believe it transmits.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      buf_written_reg <= 1'b0;
    end else if (eng_frame_begin) begin
      buf_written_reg <= 1'b0;
    end else if (byte_buffer_wr) begin
      buf_written_reg <= 1'b1;
    end
  end

  // Transmit indicator; a generated START is the strongest cause.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      transmitter_indicator_reg <= SCS_CTRL_RESET[SCS_BIT_TX];
    end else if (eng_start_gen) begin
      transmitter_indicator_reg <= 1'b1;
    end else if (arb_loss || foreign_start) begin
      transmitter_indicator_reg <= 1'b0;
    end else if (eng_frame_begin) begin
      transmitter_indicator_reg <= buf_written_reg | byte_buffer_wr;
    end
  end

  // Begin flag: software writes it, hardware only ever sets it.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      begin_condition_flag_reg <= SCS_CTRL_RESET[SCS_BIT_BEGIN];
    end else if (eng_addr_rx) begin
      begin_condition_flag_reg <= 1'b1;
    end else if (ctrl_wr) begin
      begin_condition_flag_reg <= sfr_wdata[SCS_BIT_BEGIN];
    end
  end

  // End flag: a hardware set wins over both the write and the clear.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      end_condition_flag_reg <= SCS_CTRL_RESET[SCS_BIT_END];
    end else if (slave_stop || lost_to_stop) begin
      end_condition_flag_reg <= 1'b1;
    end else if (eng_stop_gen) begin
      end_condition_flag_reg <= 1'b0;
    end else if (ctrl_wr) begin
      end_condition_flag_reg <= sfr_wdata[SCS_BIT_END];
    end
  end

  // Request for an ACK value, only used while automatic ACK is off.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_value_request_reg <= SCS_CTRL_RESET[SCS_BIT_ACK_VALUE_REQUEST];
    end else if (eng_byte_rx && !auto_acknowledge_enable) begin
      ack_value_request_reg <= 1'b1;
    end else if (eng_ack_cycle_end) begin
      ack_value_request_reg <= 1'b0;
    end
  end

  // Arbitration loss flag, cleared when software clears pending; a loss in that cycle wins.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      arbitration_lost_flag_reg <= SCS_CTRL_RESET[SCS_BIT_ARB];
    end else if (arb_loss) begin
      arbitration_lost_flag_reg <= 1'b1;
    end else if (pend_clear) begin
      arbitration_lost_flag_reg <= 1'b0;
    end
  end

  // ACK bit. A received byte that needs software's answer first parks a
  // NACK here, so clearing pending without a write sends a NACK.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_reg <= SCS_CTRL_RESET[SCS_BIT_ACK];
    end else if (eng_byte_tx) begin
      ack_reg <= eng_ack_rx_low;
    end else if (eng_byte_rx && !auto_acknowledge_enable) begin
      ack_reg <= 1'b0;
    end else if (ctrl_wr) begin
      ack_reg <= sfr_wdata[SCS_BIT_ACK];
    end
  end

  // Pending flag: an event in the clearing cycle keeps it set.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pending_reg <= SCS_CTRL_RESET[SCS_BIT_PEND];
    end else if (pend_set) begin
      pending_reg <= 1'b1;
    end else if (ctrl_wr) begin
      pending_reg <= sfr_wdata[SCS_BIT_PEND];
    end
  end

  // Status vector as software reads it.
  always_comb begin
    status = SCS_CTRL_RESET;
    status[SCS_BIT_MASTER] = master_reg;
    status[SCS_BIT_TX] = transmitter_indicator_reg;
    status[SCS_BIT_BEGIN] = begin_condition_flag_reg;
    status[SCS_BIT_END] = end_condition_flag_reg;
    status[SCS_BIT_ACK_VALUE_REQUEST] = ack_value_request_reg;
    status[SCS_BIT_ARB] = arbitration_lost_flag_reg;
    status[SCS_BIT_ACK] = ack_reg;
    status[SCS_BIT_PEND] = pending_reg;
  end

  // Read data is registered; a read of any other address returns zero.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= SCS_RDATA_IDLE;
    end else if (sfr_rd && ctrl_sel) begin
      rdata_reg <= status;
    end else begin
      rdata_reg <= SCS_RDATA_IDLE;
    end
  end

  assign sfr_rdata = rdata_reg;

  // The whole engine waits while pending is set.
  assign stall = pending_reg;

  // START waits for a free bus unless we already own it. A pending STOP
  // holds the START back, so with both flags set while master the STOP goes first.
  assign start_req = begin_condition_flag_reg & ~pending_reg & ~stop_req
    & (master_reg | free_s2_reg);
  assign stop_req = end_condition_flag_reg & master_reg & ~pending_reg;

  assign transmitter_indicator = transmitter_indicator_reg;

  // Interrupt request follows the pending flag with no extra latency.
  assign irq = pending_reg;

  // SCL is held low for as long as pending stays set.
  assign lk_if.scl_hold = pending_reg;

  // While receiving, the ACK bit goes onto SDA in the acknowledge slot.
  // The slot is the engine's, so this stays correct in both ACK modes.
  assign lk_if.sda_low = eng_ack_slot & ~transmitter_indicator_reg & ack_reg;

endmodule // scs_ctrl

// ===== hw/scs_pkg.sv
// Constants shared by the serial bus control and status logic.
package scs_pkg;

  // Address of the control and status register on the core's register port.
  localparam logic [7:0] SCS_CTRL_ADDR = 8'hc0;

  // Every bit of the register clears to zero on reset.
  localparam logic [7:0] SCS_CTRL_RESET = 8'h00;

  // Bit positions inside the control and status register.
  localparam int unsigned SCS_BIT_MASTER = 7;
  localparam int unsigned SCS_BIT_TX = 6;
  localparam int unsigned SCS_BIT_BEGIN = 5;
  localparam int unsigned SCS_BIT_END = 4;
  localparam int unsigned SCS_BIT_ACK_VALUE_REQUEST = 3;
  localparam int unsigned SCS_BIT_ARB = 2;
  localparam int unsigned SCS_BIT_ACK = 1;
  localparam int unsigned SCS_BIT_PEND = 0;

  // Value read back for a register port read that hits no register.
  localparam logic [7:0] SCS_RDATA_IDLE = 8'h00;

  // The bus counts as free after reset until a START is seen.
  localparam logic SCS_BUS_FREE_RESET = 1'b1;

endpackage

// ===== hw/scs_link_if.sv
// Signals crossing between the core-side register logic and the pin-side logic.
interface scs_link_if;
  logic scl_hold;
  logic sda_low;
  logic start_tgl;
  logic stop_tgl;
  logic bus_free;

  modport core (
    output scl_hold,
    output sda_low,
    input start_tgl,
    input stop_tgl,
    input bus_free
  );

  modport link (
    input scl_hold,
    input sda_low,
    output start_tgl,
    output stop_tgl,
    output bus_free
  );
endinterface

// ===== hw/scs_link.sv
// Pin-side logic on the link clock: condition detection and open-drain drives.
module scs_link
  import scs_pkg::*;
(
  input wire logic link_clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe,
  output logic sda_out,
  output logic sda_oe,
  scs_link_if.link lk
);

  logic scl_s1_reg, scl_s2_reg, sda_s1_reg, sda_s2_reg, sda_prev_reg;
  logic hold_s1_reg, hold_s2_reg, low_s1_reg, low_s2_reg;
  logic start_tgl_reg, stop_tgl_reg, bus_free_reg;
  logic start_seen, stop_seen;

  // Two stages on the pins before any detection looks at them.
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_s1_reg <= scl_in;
      scl_s2_reg <= scl_s1_reg;
      sda_s1_reg <= sda_in;
      sda_s2_reg <= sda_s1_reg;
      sda_prev_reg <= sda_s2_reg;
    end
  end

  // START is SDA falling with SCL high, STOP is SDA rising with SCL high.
  assign start_seen = scl_s2_reg & sda_prev_reg & ~sda_s2_reg;
  assign stop_seen = scl_s2_reg & ~sda_prev_reg & sda_s2_reg;

  // Conditions leave this domain as toggles so none is lost at any clock ratio.
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      start_tgl_reg <= 1'b0;
      stop_tgl_reg <= 1'b0;
      bus_free_reg <= SCS_BUS_FREE_RESET;
    end else begin
      start_tgl_reg <= start_tgl_reg ^ start_seen;
      stop_tgl_reg <= stop_tgl_reg ^ stop_seen;
      if (start_seen) begin
        bus_free_reg <= 1'b0;
      end else if (stop_seen) begin
        bus_free_reg <= 1'b1;
      end
    end
  end

  // Drive requests are levels from the core clock and pass two stages here.
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      hold_s1_reg <= 1'b0;
      hold_s2_reg <= 1'b0;
      low_s1_reg <= 1'b0;
      low_s2_reg <= 1'b0;
    end else begin
      hold_s1_reg <= lk.scl_hold;
      hold_s2_reg <= hold_s1_reg;
      low_s1_reg <= lk.sda_low;
      low_s2_reg <= low_s1_reg;
    end
  end

  // Both lines are open drain: only ever pulled low, never driven high.
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = hold_s2_reg;
  assign sda_oe = low_s2_reg;
  assign lk.start_tgl = start_tgl_reg;
  assign lk.stop_tgl = stop_tgl_reg;
  assign lk.bus_free = bus_free_reg;

endmodule // scs_link

// ===== verif/scs_bus_model.sv
// Far party on the two-wire bus: pull-ups plus a second open-drain driver.
module scs_bus_model (
  input wire logic scl_oe,
  input wire logic sda_oe,
  output logic scl_in,
  output logic sda_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic scl_low = 1'b0;
  logic sda_low = 1'b0;
  // A released line returns to the pull-up level, never to its last driven value.
  assign scl_in = !(scl_oe || scl_low);
  assign sda_in = !(sda_oe || sda_low);
  // Moves the foreign lines, then leaves time for the pin synchronisers.
  task automatic drive(input logic scl_l, input logic sda_l);
    scl_low = scl_l;
    sda_low = sda_l;
    #400;
  endtask
endmodule // scs_bus_model

// ===== verif/scs_ctrl_checker.sv
// Concurrent checks on the ports of the control and status block.
module scs_ctrl_checker
  import scs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic eng_start_gen,
  input wire logic eng_byte_rx,
  input wire logic eng_scl_low_arb,
  input wire logic eng_sda_low_arb,
  input wire logic start_req,
  input wire logic stop_req,
  input wire logic stall,
  input wire logic transmitter_indicator,
  input wire logic irq,
  input wire logic scl_oe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // Pending held long enough for the link side to catch up.
  sequence s_stall_held;
    stall [*4];
  endsequence
  sequence s_pend_force;
    sfr_wr && sfr_addr == SCS_CTRL_ADDR && sfr_wdata[SCS_BIT_PEND];
  endsequence
  sequence s_arb_only;
    (eng_scl_low_arb || eng_sda_low_arb) && !eng_start_gen;
  endsequence
  a_irq_follows_pend: assert property (irq == stall)
    else $error("irq differs from stall");
  a_pend_blocks_req: assert property (stall |-> !start_req && !stop_req)
    else $error("request while pending");
  a_stop_before_start: assert property (stop_req |-> !start_req)
    else $error("start with stop");
  a_rx_sets_pend: assert property (eng_byte_rx |=> irq)
    else $error("no pending after byte");
  a_start_sets_tx: assert property (eng_start_gen |=> transmitter_indicator)
    else $error("no transmit after start");
  a_arb_clears_tx: assert property (s_arb_only |=> !transmitter_indicator && irq)
    else $error("arbitration loss not seen");
  a_force_pend: assert property (s_pend_force |=> irq)
    else $error("forced pending missing");
  a_rdata_idle: assert property (!(sfr_rd && sfr_addr == SCS_CTRL_ADDR) |=> sfr_rdata == SCS_RDATA_IDLE)
    else $error("read data not idle");
  a_scl_held_low: assert property (s_stall_held |-> scl_oe)
    else $error("clock not held");
endmodule // scs_ctrl_checker

bind scs_ctrl scs_ctrl_checker scs_ctrl_checker_i (
  .clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
  .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .eng_start_gen(eng_start_gen), .eng_byte_rx(eng_byte_rx),
  .eng_scl_low_arb(eng_scl_low_arb), .eng_sda_low_arb(eng_sda_low_arb), .start_req(start_req),
  .stop_req(stop_req), .stall(stall), .transmitter_indicator(transmitter_indicator), .irq(irq),
  .scl_oe(scl_oe)
);

// ===== verif/scs_ctrl_tb.sv
// Self-checking bench for the control and status block.
module scs_ctrl_tb
  import scs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_rd = 1'b0;
  logic [9:0] ev = 10'h000;
  logic auto_ack = 1'b0;
  logic ack_low = 1'b0;
  logic addressed = 1'b0;
  logic ack_slot = 1'b0;
  logic [7:0] sfr_rdata;
  logic start_req, stop_req, stall, tx_ind, irq, scl_in, sda_in, scl_oe, sda_oe;
  logic [7:0] m = 8'h00;
  int mismatches = 0;
  int cmp_count = 0;
  int cyc = 0;
  int seed = 32'h5a7b70dd;

  scs_ctrl scs_ctrl_i (
    .clk(clk), .rst(rst), .link_clk(link_clk), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .byte_buffer_wr(ev[9]),
    .auto_acknowledge_enable(auto_ack), .eng_start_gen(ev[0]), .eng_stop_gen(ev[1]),
    .eng_frame_begin(ev[2]), .eng_byte_tx(ev[3]), .eng_ack_rx_low(ack_low), .eng_byte_rx(ev[4]),
    .eng_addr_rx(ev[5]), .eng_addressed(addressed), .eng_ack_slot(ack_slot),
    .eng_ack_cycle_end(ev[6]), .eng_scl_low_arb(ev[7]), .eng_sda_low_arb(ev[8]),
    .start_req(start_req), .stop_req(stop_req), .stall(stall), .transmitter_indicator(tx_ind),
    .irq(irq), .scl_in(scl_in), .scl_out(), .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(),
    .sda_oe(sda_oe)
  );
  scs_bus_model scs_bus_model_i (.scl_oe(scl_oe), .sda_oe(sda_oe), .scl_in(scl_in), .sda_in(sda_in));

  // Core clock, and a link clock with no fixed phase to it.
  initial begin
    forever #50 clk = ~clk;
  end
  initial begin
    #7;
    forever #16 link_clk = ~link_clk;
  end

  task automatic wrap_up;
    if (mismatches == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // The whole run is about two hundred cycles, so this ceiling only trips on a hang.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      wrap_up;
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    #1;
    chk(sfr_rdata, exp);
  endtask

  // Reference register: read-only bits keep their value, pending cleared drops arbitration loss.
  task automatic wr_m(input logic [7:0] d);
    wr(SCS_CTRL_ADDR, d);
    m = {m[7:6], d[5:4], m[3], m[2] & d[0], d[1:0]};
  endtask

  task automatic rd_m;
    rd_chk(SCS_CTRL_ADDR, m);
    chk({7'h0, irq}, {7'h0, m[0]});
    chk({7'h0, tx_ind}, {7'h0, m[6]});
  endtask

  task automatic pulse(input logic [9:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= 10'h000;
  endtask

  // Waits for the clock hold to lift, so the foreign party sees SCL high.
  task automatic cond(input logic sda_l);
    repeat (3) @(posedge clk);
    scs_bus_model_i.drive(1'b0, sda_l);
    repeat (8) @(posedge clk);
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd_m;
    rd_chk(8'h3f, SCS_RDATA_IDLE);
    wr(8'h3f, 8'hff);
    wr_m(8'hff);
    rd_m;
    wr_m(8'h20);
    #1;
    chk({7'h0, start_req}, 8'h01);
    pulse(10'h001);
    m = m | 8'hc1;
    rd_m;
    wr_m(8'h30);
    #1;
    chk({6'h0, start_req, stop_req}, 8'h01);
    pulse(10'h002);
    m = m & 8'h6f;
    rd_m;
    // Received byte in manual and automatic acknowledge modes.
    for (int a = 0; a < 2; a++) begin
      wr_m(8'h02);
      @(posedge clk) auto_ack <= a[0];
      pulse(10'h010);
      m[0] = 1'b1;
      if (a == 0) begin
        m[3] = 1'b1;
        m[1] = 1'b0;
      end
      rd_m;
      wr_m(8'h03);
      pulse(10'h040);
      m[3] = 1'b0;
      rd_m;
    end
    repeat (4) begin
      @(posedge clk);
      ack_low <= 1'($random(seed));
      ack_slot <= 1'($random(seed));
      pulse(10'h008);
      m[1] = ack_low;
      m[0] = 1'b1;
      rd_m;
    end
    for (int b = 0; b < 2; b++) begin
      pulse({b[0], 9'h004});
      m[6] = b[0];
      rd_m;
      chk({7'h0, sda_oe}, {7'h0, ack_slot & ~m[6] & m[1]});
    end
    for (int k = 7; k < 9; k++) begin
      wr_m(8'h00);
      pulse(10'h001);
      m = m | 8'hc1;
      pulse(10'(1 << k));
      m = (m & 8'h3b) | 8'h05;
      rd_m;
      wr_m(8'h00);
      rd_m;
    end
    @(posedge clk) addressed <= 1'b1;
    pulse(10'h020);
    m = m | 8'h21;
    rd_m;
    @(posedge clk) addressed <= 1'b0;
    // Foreign START, then foreign STOP, while master.
    for (int s = 1; s >= 0; s--) begin
      wr_m(8'h00);
      pulse(10'h001);
      m = m | 8'hc1;
      wr_m(8'h00);
      cond(s[0]);
      m = (m & 8'h3b) | (s == 1 ? 8'h05 : 8'h15);
      rd_m;
    end
    wr_m(8'h00);
    @(posedge clk) addressed <= 1'b1;
    cond(1'b1);
    cond(1'b0);
    m = m | 8'h11;
    rd_m;
    wrap_up;
  end
endmodule // scs_ctrl_tb
